//--- common/cic_ports_params.svh
// Named constants shared by the filter stream ends and their buffer.
// Assumes inclusion by bare name from the package and the interface.
`ifndef CIC_PORTS_PARAMS_SVH
`define CIC_PORTS_PARAMS_SVH
`define BYTE_W 8
`define IN_W_DEF 18
`define MAX_RATE_DEF 8192
`define MIN_RATE_DEF 4
`define INIT_RATE_DEF 8
`define NCH_DEF 4
`define FIFO_DEPTH_DEF 16
`define READY_LAT_DEF 3
`define CLEAR_CYCLES_DEF 2
`endif

//--- common/cic_pkg.sv
// Types and width helpers for the filter stream ends.
// Assumes the constants header is on the include path.
`include "cic_ports_params.svh"
package cic_pkg;
  // Rounds a field width up to the next byte boundary.
  function automatic int pad8(input int w);
    return ((w + `BYTE_W - 1) / `BYTE_W) * `BYTE_W;
  endfunction

  function automatic int chan_w(input int n);
    return (n > 1) ? $clog2(n) : 1;
  endfunction

  typedef enum logic [1:0] {
    CFG_IDLE = 2'h1,
    CFG_SEND = 2'h2
  } cfg_state_t;
endpackage

//--- common/cic_stream_if.sv
// Stream channels between the filter and its upstream and downstream logic.
// Assumes both ends share one clock; the interface carries no clock itself.
`timescale 1ns/10ps
`default_nettype none
`include "cic_ports_params.svh"
interface cic_stream_if
  import cic_pkg::*;
#(
  parameter int IN_W = `IN_W_DEF,
  parameter int MAX_RATE = `MAX_RATE_DEF,
  parameter int NCH = `NCH_DEF
);
  localparam int RATE_W = $clog2(MAX_RATE + 1);
  localparam int CFG_PAD = pad8(RATE_W);
  localparam int IN_PAD = pad8(IN_W);
  localparam int OUT_PAD = pad8(IN_W + RATE_W);
  localparam int USER_W = pad8(chan_w(NCH)) + `BYTE_W;
  logic ce;
  logic clear_n;
  logic cfg_valid;
  logic cfg_ready;
  logic [CFG_PAD-1:0] cfg_data;
  logic din_valid;
  logic din_ready;
  logic [IN_PAD-1:0] din_data;
  logic din_last;
  logic dout_valid;
  logic dout_ready;
  logic [OUT_PAD-1:0] dout_data;
  logic [USER_W-1:0] dout_user;
  logic dout_last;
  logic evt_missing_last;
  logic evt_unexpected_last;
  logic evt_halted;

  modport device (
    input ce, clear_n, cfg_valid, cfg_data, din_valid, din_data, din_last, dout_ready,
    output cfg_ready, din_ready, dout_valid, dout_data, dout_user, dout_last,
    output evt_missing_last, evt_unexpected_last, evt_halted
  );
  modport source (
    output ce, clear_n, cfg_valid, cfg_data, din_valid, din_data, din_last, dout_ready,
    input cfg_ready, din_ready, dout_valid, dout_data, dout_user, dout_last,
    input evt_missing_last, evt_unexpected_last, evt_halted
  );
endinterface // cic_stream_if
`default_nettype wire

//--- verilog/cic_ports_device.sv
// Filter end of the stream link: input buffer, per-channel decimating
// accumulator, rate channel and output stage with optional backpressure.
// Assumes one clock shared with the far end and inputs synchronous to it.
//
// Notes on behaviour
// - Transfer only when valid and ready high.
// - Sender drives valid, receiver drives ready.
// - Each channel has valid and data at least.
// - Sub-fields packed from bit zero upward.
// - Vectors padded to whole bytes.
// - Rate channel exists only in programmable builds; here fixed builds keep it, with cfg_ready held low.
// - Rate field starts at bit zero.
// - Padding above rate field ignored.
// - Rate ready only when a value fits.
// - Clear held low two cycles minimum.
// - Ready option adds three or more cycles.
// - Source may hold input valid high.
// - All data moves through stream channels.
// - Input samples two to thirty-two bits.
// - Output sample sign-extended to byte boundary.
// - Last flag marks final channel sample.
// - User carries channel number, then first flag.
`timescale 1ns/10ps
`default_nettype none
`include "cic_ports_params.svh"

// ----------------------------------------------------------------------
// Sample buffer
// ----------------------------------------------------------------------
module cic_sample_fifo
  import cic_pkg::*;
#(
  parameter int W = `IN_W_DEF + 1,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ready;
    logic valid;
  } fifo_t;

  function automatic fifo_t fifo_init();
    fifo_t s;
    s = '0;
    s.ready = 1'h1;
    return s;
  endfunction

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  localparam fifo_t FIFO_RST = fifo_init();

  fifo_t q;
  fifo_t d;
  logic push;
  logic pop;

  always_comb begin
    d = q;
    push = in_valid && q.ready && ce;
    pop = out_ready && q.valid && ce;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = step(q.wr);
    end
    if (pop) begin
      d.rd = step(q.rd);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + CW'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - CW'(1);
    end
    // Flags are registered so the filling side sees ready straight from a flop.
    d.ready = (d.cnt != CW'(DEPTH));
    d.valid = (d.cnt != '0);
    if (clear) begin
      d = FIFO_RST;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= FIFO_RST;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.ready;
  assign out_valid = q.valid;
  assign out_data = q.mem[q.rd];
endmodule // cic_sample_fifo

// ----------------------------------------------------------------------
// Filter stream end
// ----------------------------------------------------------------------
module cic_ports_device
  import cic_pkg::*;
#(
  parameter int IN_W = `IN_W_DEF,
  parameter int MAX_RATE = `MAX_RATE_DEF,
  parameter int MIN_RATE = `MIN_RATE_DEF,
  parameter int INIT_RATE = `INIT_RATE_DEF,
  parameter int NCH = `NCH_DEF,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF,
  parameter bit PROG_RATE = 1'b1,
  parameter bit HAS_DOUT_READY = 1'b1
) (
  input wire logic clock,
  input wire logic arst_n,
  cic_stream_if.device bus,
  output logic [$clog2(MAX_RATE + 1)-1:0] rate_now
);
  localparam int RATE_W = $clog2(MAX_RATE + 1);
  localparam int ACC_W = IN_W + RATE_W;
  localparam int CH_W = chan_w(NCH);
  localparam int CH_PAD = pad8(CH_W);
  localparam int OUT_PAD = pad8(ACC_W);
  localparam int LAT = `READY_LAT_DEF;

  // Channel flags travel with the beat so the stream outputs come straight from flops.
  typedef struct packed {
    logic [ACC_W-1:0] data;
    logic [CH_W-1:0] ch;
    logic first;
    logic last;
  } beat_t;

  typedef struct packed {
    logic [NCH-1:0][ACC_W-1:0] acc;
    logic [CH_W-1:0] ch;
    logic [RATE_W-1:0] phase;
    logic [RATE_W-1:0] rate;
    logic [RATE_W-1:0] rate_next;
    logic rate_pend;
    logic cfg_ready;
    beat_t [LAT-1:0] pipe;
    logic [LAT-1:0] pv;
    beat_t outb;
    logic ov;
    logic miss;
    logic unexp;
    logic halted;
  } state_t;

  function automatic state_t state_init();
    state_t s;
    s = '0;
    s.rate = RATE_W'(INIT_RATE);
    s.cfg_ready = PROG_RATE;
    return s;
  endfunction

  localparam state_t ST_RST = state_init();

  state_t q;
  state_t d;
  logic fifo_valid;
  logic [IN_W:0] fifo_data;
  logic stall;
  logic pop;
  logic emit;
  logic last_ch;
  logic [ACC_W-1:0] sum;
  logic [RATE_W-1:0] cfg_rate;

  // Padding bits of the input are dropped at the buffer, so they cost nothing.
  cic_sample_fifo #(
    .W(IN_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .ce(bus.ce),
    .clear(!bus.clear_n),
    .in_valid(bus.din_valid),
    .in_ready(bus.din_ready),
    .in_data({bus.din_last, bus.din_data[IN_W-1:0]}),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  always_comb begin
    d = q;
    d.miss = 1'h0;
    d.unexp = 1'h0;
    stall = HAS_DOUT_READY && q.ov && !bus.dout_ready;
    pop = fifo_valid && !stall && bus.ce;
    last_ch = (q.ch == CH_W'(NCH - 1));
    emit = (q.phase == q.rate - RATE_W'(1));
    sum = q.acc[q.ch] + ACC_W'(signed'(fifo_data[IN_W-1:0]));
    cfg_rate = bus.cfg_data[RATE_W-1:0];
    if (cfg_rate < RATE_W'(MIN_RATE)) begin
      cfg_rate = RATE_W'(MIN_RATE);
    end else if (cfg_rate > RATE_W'(MAX_RATE)) begin
      cfg_rate = RATE_W'(MAX_RATE);
    end
    if (bus.ce) begin
      d.halted = stall;
      if (pop) begin
        d.acc[q.ch] = emit ? '0 : sum;
        d.miss = last_ch && !fifo_data[IN_W];
        d.unexp = !last_ch && fifo_data[IN_W];
        if (last_ch) begin
          d.ch = '0;
          if (emit) begin
            d.phase = '0;
            // A new rate only takes hold between decimation periods.
            if (q.rate_pend) begin
              d.rate = q.rate_next;
              d.rate_pend = 1'h0;
            end
          end else begin
            d.phase = q.phase + RATE_W'(1);
          end
        end else begin
          d.ch = q.ch + CH_W'(1);
        end
      end
      if (HAS_DOUT_READY) begin
        // Extra stages give a variable latency that is at least LAT cycles longer.
        if (!stall) begin
          d.pipe[0] = '{data: sum, ch: q.ch, first: q.ch == '0, last: last_ch};
          d.pv[0] = pop && emit;
          for (int i = 1; i < LAT; i++) begin
            d.pipe[i] = q.pipe[i-1];
            d.pv[i] = q.pv[i-1];
          end
          d.ov = q.pv[LAT-1];
          d.outb = q.pipe[LAT-1];
        end
      end else begin
        d.ov = pop && emit;
        if (pop && emit) begin
          d.outb = '{data: sum, ch: q.ch, first: q.ch == '0, last: last_ch};
        end
      end
      if (PROG_RATE && bus.cfg_valid && q.cfg_ready) begin
        d.rate_next = cfg_rate;
        d.rate_pend = 1'h1;
      end
      d.cfg_ready = PROG_RATE && !d.rate_pend;
    end
    if (!bus.clear_n) begin
      d = ST_RST;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Stream outputs
  // ----------------------------------------------------------------------
  assign bus.cfg_ready = q.cfg_ready;
  assign bus.dout_valid = q.ov;
  assign bus.dout_data = OUT_PAD'(signed'(q.outb.data));
  assign bus.dout_user = {7'h00, q.outb.first, CH_PAD'(q.outb.ch)};
  assign bus.dout_last = q.outb.last;
  assign bus.evt_missing_last = q.miss;
  assign bus.evt_unexpected_last = q.unexp;
  assign bus.evt_halted = q.halted;
  assign rate_now = q.rate;
endmodule // cic_ports_device
`default_nettype wire

//--- verilog/cic_ports_host.sv
// Upstream source and downstream consumer end of the filter stream link.
// Assumes the same clock as the filter; user-side inputs are synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "cic_ports_params.svh"
module cic_ports_host
  import cic_pkg::*;
#(
  parameter int IN_W = `IN_W_DEF,
  parameter int MAX_RATE = `MAX_RATE_DEF,
  parameter int NCH = `NCH_DEF,
  parameter int CLEAR_CYCLES = `CLEAR_CYCLES_DEF,
  parameter bit HAS_DOUT_READY = 1'b1
) (
  input wire logic clock,
  input wire logic arst_n,
  cic_stream_if.source bus,
  input wire logic run_en,
  input wire logic clear_req,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [IN_W-1:0] src_data,
  input wire logic src_last,
  input wire logic rate_req,
  input wire logic [$clog2(MAX_RATE + 1)-1:0] rate_value,
  output logic rate_busy,
  input wire logic sink_stall,
  output logic sink_valid,
  output logic [pad8(IN_W + $clog2(MAX_RATE + 1))-1:0] sink_data,
  output logic [pad8(chan_w(NCH)) + `BYTE_W-1:0] sink_user,
  output logic sink_last,
  output logic [2:0] events
);
  localparam int RATE_W = $clog2(MAX_RATE + 1);
  localparam int IN_PAD = pad8(IN_W);
  localparam int CFG_PAD = pad8(RATE_W);
  localparam int OUT_PAD = pad8(IN_W + RATE_W);
  localparam int USER_W = pad8(chan_w(NCH)) + `BYTE_W;
  localparam int CNT_W = $clog2(CLEAR_CYCLES + 1);

  typedef struct packed {
    logic ce;
    logic [CNT_W-1:0] clr_cnt;
    logic clear_n;
    logic dv;
    logic [IN_PAD-1:0] dd;
    logic dl;
    logic src_ready;
    cfg_state_t st;
    logic [CFG_PAD-1:0] cd;
    logic dout_ready;
    logic sv;
    logic [OUT_PAD-1:0] sd;
    logic [USER_W-1:0] su;
    logic sl;
    logic [2:0] ev;
  } host_t;

  localparam host_t HOST_RST = '{st: CFG_IDLE, clear_n: 1'h1, default: '0};

  host_t q;
  host_t d;

  always_comb begin
    d = q;
    d.sv = 1'h0;
    d.ce = run_en;
    d.ev = {bus.evt_halted, bus.evt_unexpected_last, bus.evt_missing_last};
    // A clear request holds the filter clear for a full minimum pulse.
    if (clear_req) begin
      d.clr_cnt = CNT_W'(CLEAR_CYCLES);
    end else if (q.clr_cnt != '0) begin
      d.clr_cnt = q.clr_cnt - CNT_W'(1);
    end
    d.clear_n = (d.clr_cnt == '0);
    if (q.dv && bus.din_ready && q.ce) begin
      d.dv = 1'h0;
    end
    if (q.src_ready && src_valid) begin
      d.dv = 1'h1;
      d.dd = IN_PAD'(src_data);
      d.dl = src_last;
    end
    case (q.st)
      CFG_IDLE: begin
        if (rate_req) begin
          d.cd = CFG_PAD'(rate_value);
          d.st = CFG_SEND;
        end
      end
      CFG_SEND: begin
        if (bus.cfg_ready && q.ce) begin
          d.st = CFG_IDLE;
        end
      end
      default: begin
        d.st = CFG_IDLE;
      end
    endcase
    d.dout_ready = !sink_stall;
    if (bus.dout_valid && (q.dout_ready || !HAS_DOUT_READY) && q.ce && q.clear_n) begin
      d.sv = 1'h1;
      d.sd = bus.dout_data;
      d.su = bus.dout_user;
      d.sl = bus.dout_last;
    end
    // The filter drops everything on clear, so the source drops its pending word too.
    if (!d.clear_n) begin
      d.dv = 1'h0;
      d.st = CFG_IDLE;
    end
    d.src_ready = !d.dv && d.clear_n;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.ce = q.ce;
  assign bus.clear_n = q.clear_n;
  assign bus.din_valid = q.dv;
  assign bus.din_data = q.dd;
  assign bus.din_last = q.dl;
  assign bus.cfg_valid = q.st[1];
  assign bus.cfg_data = q.cd;
  assign bus.dout_ready = q.dout_ready;
  assign src_ready = q.src_ready;
  assign rate_busy = q.st[1];
  assign sink_valid = q.sv;
  assign sink_data = q.sd;
  assign sink_user = q.su;
  assign sink_last = q.sl;
  assign events = q.ev;
endmodule // cic_ports_host
`default_nettype wire

//--- tb/cic_link_properties.sv
// Concurrent checks on the stream link between the filter end and the host end.
// Assumes one clock and the link's signals wired in by name from the bench.
`timescale 1ns/10ps
`default_nettype none
`include "cic_ports_params.svh"
module cic_link_properties
  import cic_pkg::*;
#(
  parameter int IN_W = `IN_W_DEF,
  parameter int MAX_RATE = `MAX_RATE_DEF,
  parameter int NCH = `NCH_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clear_n,
  input wire logic cfg_valid,
  input wire logic cfg_ready,
  input wire logic din_ready,
  input wire logic dout_valid,
  input wire logic dout_ready,
  input wire logic [pad8(IN_W + $clog2(MAX_RATE + 1))-1:0] dout_data,
  input wire logic [pad8(chan_w(NCH)) + `BYTE_W-1:0] dout_user,
  input wire logic dout_last,
  input wire logic evt_missing_last,
  input wire logic evt_halted
);
  localparam int OW = IN_W + $clog2(MAX_RATE + 1);
  localparam int OP = pad8(OW);
  localparam int CW = chan_w(NCH);
  localparam int CP = pad8(CW);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_DOUT_HOLD: assert property (
    dout_valid && !dout_ready && clear_n |=> dout_valid && $stable(dout_data)
      && $stable(dout_user) && $stable(dout_last))
    else $error("output beat changed while stalled");
  AST_LAST_CHAN: assert property (
    dout_valid |-> dout_last == (dout_user[CW-1:0] == CW'(NCH - 1)))
    else $error("last flag not on final channel");
  AST_USER_FIELDS: assert property (
    dout_valid |-> dout_user[CP] == (dout_user[CW-1:0] == '0)
      && dout_user[CP-1:CW] == '0 && dout_user[CP+7:CP+1] == '0)
    else $error("user fields misplaced");
  AST_SIGN_EXT: assert property (
    dout_valid |-> dout_data[OP-1:OW-1] == '0 || dout_data[OP-1:OW-1] == '1)
    else $error("output not sign extended");
  AST_CE_FREEZE: assert property (
    !ce && clear_n |=> $stable(dout_valid) && $stable(din_ready)
      && $stable(cfg_ready) && $stable(dout_data))
    else $error("state moved with clock enable low");
  AST_CLEAR_STATE: assert property (
    !clear_n |=> !dout_valid && din_ready && cfg_ready)
    else $error("clear did not restore idle state");
  AST_CFG_TAKEN: assert property (
    ce && clear_n && cfg_valid && cfg_ready |=> !cfg_ready)
    else $error("rate ready stayed high after transfer");
  AST_EVT_PULSE: assert property (
    evt_missing_last && ce |=> !evt_missing_last)
    else $error("missing last event longer than one cycle");
  AST_HALTED: assert property (
    (dout_valid && !dout_ready && ce && clear_n)[*3] |-> evt_halted)
    else $error("halted event absent during stall");

  COV_DOUT: cover property (dout_valid && dout_ready);
  COV_CFG: cover property (cfg_valid && cfg_ready && ce);
  COV_HALT: cover property (evt_halted);
  COV_MISS: cover property (evt_missing_last);
endmodule // cic_link_properties
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: host end and filter end joined by the stream link.
// Assumes the design files and the link checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "cic_ports_params.svh"
module tb;
  import cic_pkg::*;
  localparam int NCH = 4;
  logic clock = 1'b0, arst_n = 1'b0, run_en = 1'b0, clear_req = 1'b0;
  logic src_valid = 1'b0, src_last = 1'b0, rate_req = 1'b0, sink_stall = 1'b0;
  logic src_ready, rate_busy, sink_valid, sink_last;
  logic [15:0] src_data = 16'h0000;
  logic [13:0] rate_value = 14'h0000;
  logic [13:0] rate_now;
  logic [31:0] sink_data;
  logic [15:0] sink_user;
  logic [2:0] events;
  logic [2:0] seen = 3'h0;
  logic [31:0] q_data[$];
  logic [15:0] q_user[$];
  logic q_last[$];
  int fail_count = 0;
  int comparisons = 0;
  int n;
  int cyc = 0;
  int t_ready = 0;
  int t_fix = 0;
  int fix_count = 0;
  logic fix_cfg_seen = 1'b0;

  cic_stream_if #(.IN_W(16)) link ();
  cic_ports_device #(.IN_W(16)) i_cic_ports_device (.clock, .arst_n, .bus(link), .rate_now);
  cic_ports_host #(.IN_W(16)) i_cic_ports_host (.clock, .arst_n, .bus(link), .run_en,
    .clear_req, .src_valid, .src_ready, .src_data, .src_last, .rate_req, .rate_value,
    .rate_busy, .sink_stall, .sink_valid, .sink_data, .sink_user, .sink_last, .events);
  cic_link_properties #(.IN_W(16)) i_cic_link_properties (.clock, .arst_n, .ce(link.ce),
    .clear_n(link.clear_n), .cfg_valid(link.cfg_valid), .cfg_ready(link.cfg_ready),
    .din_ready(link.din_ready), .dout_valid(link.dout_valid), .dout_ready(link.dout_ready),
    .dout_data(link.dout_data), .dout_user(link.dout_user), .dout_last(link.dout_last),
    .evt_missing_last(link.evt_missing_last), .evt_halted(link.evt_halted));

  // A fixed-rate build without output ready shadows the link; it sees each accepted
  // sample once, so its output count and timing can be held against the main build.
  cic_stream_if #(.IN_W(16)) link_fix ();
  cic_ports_device #(.IN_W(16), .PROG_RATE(1'b0), .HAS_DOUT_READY(1'b0))
    i_cic_ports_device_fix (.clock, .arst_n, .bus(link_fix), .rate_now());
  assign link_fix.ce = link.ce;
  assign link_fix.clear_n = link.clear_n;
  assign link_fix.cfg_valid = link.cfg_valid;
  assign link_fix.cfg_data = link.cfg_data;
  assign link_fix.din_valid = link.din_valid && link.din_ready;
  assign link_fix.din_data = link.din_data;
  assign link_fix.din_last = link.din_last;
  assign link_fix.dout_ready = link.dout_ready;

  always #50 clock = ~clock;

  always @(posedge clock) begin
    seen <= seen | events;
    cyc <= cyc + 1;
    if (link.dout_valid === 1'b1 && t_ready == 0) t_ready <= cyc;
    if (link_fix.dout_valid === 1'b1) fix_count <= fix_count + 1;
    if (link_fix.dout_valid === 1'b1 && t_fix == 0) t_fix <= cyc;
    if (arst_n && link_fix.cfg_ready !== 1'b0) fix_cfg_seen <= 1'b1;
    if (sink_valid === 1'b1) begin
      q_data.push_back(sink_data);
      q_user.push_back(sink_user);
      q_last.push_back(sink_last);
    end
  end

  // ----------------------------------------------------------------------
  // Drivers and comparisons
  // ----------------------------------------------------------------------
  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask

  function automatic int val(input int c);
    return c * 3 - 5;
  endfunction

  // Called at a falling edge; src_ready is a flop, so it is settled here.
  task automatic put(input int v, input logic lst, input int lim, output bit ok);
    src_data = 16'(v);
    src_last = lst;
    src_valid = 1'b1;
    for (int k = 0; k < lim && src_ready !== 1'b1; k++) @(negedge clock);
    ok = (src_ready === 1'b1);
    if (ok) @(negedge clock);
  endtask

  // A refused sample is left pending so a later call can resume from it.
  task automatic feed(input int from, input int upto, input int lc, input int lim,
      input int hold_at, output int sent);
    bit ok;
    sent = from;
    for (int i = from; i < upto; i++) begin
      if (i == hold_at) begin
        // Valid must drop first, or the host would take the last sample a second time.
        src_valid = 1'b0;
        run_en = 1'b0;
        repeat (6) @(negedge clock);
        run_en = 1'b1;
      end
      put(val(i % NCH), 1'((i % NCH) == lc), lim, ok);
      if (!ok) return;
      sent++;
    end
    src_valid = 1'b0;
  endtask

  task automatic expect_out(input int per, input int rate);
    int c;
    for (int k = 0; k < 400 && q_data.size() < per * NCH; k++) @(negedge clock);
    check_vec(32'(q_data.size()), 32'(per * NCH), "output count");
    for (int p = 0; p < per * NCH && q_data.size() > 0; p++) begin
      c = p % NCH;
      check_vec(q_data.pop_front(), 32'(rate * val(c)), "sum");
      check_vec({16'h0000, q_user.pop_front()}, {23'h000000, 1'(c == 0), 8'(c)}, "user");
      check_bit(q_last.pop_front(), 1'(c == NCH - 1), "last");
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_stream();
    seen = 3'h0;
    feed(0, 64, 3, 200, 37, n);
    expect_out(2, 8);
    check_vec({29'h00000000, seen}, 32'h00000000, "events");
    check_vec(32'(fix_count), 32'h00000008, "fixed build outputs");
    check_vec(32'(t_ready - t_fix), 32'(`READY_LAT_DEF), "extra latency");
    $display("test stream done");
  endtask

  task automatic test_rate();
    rate_value = 14'h0002;
    rate_req = 1'b1;
    @(negedge clock);
    rate_req = 1'b0;
    feed(0, 32, 3, 200, -1, n);
    expect_out(1, 8);
    check_bit(rate_busy, 1'b0, "rate busy");
    check_bit(fix_cfg_seen, 1'b0, "fixed build rate ready");
    check_vec(32'(rate_now), 32'h00000004, "clamped rate");
    feed(0, 16, 3, 200, -1, n);
    expect_out(1, 4);
    $display("test rate done");
  endtask

  task automatic test_last();
    seen = 3'h0;
    feed(0, 16, 1, 200, -1, n);
    expect_out(1, 4);
    check_bit(seen[0], 1'b1, "missing last");
    check_bit(seen[1], 1'b1, "unexpected last");
    $display("test last done");
  endtask

  task automatic test_stall();
    sink_stall = 1'b1;
    seen = 3'h0;
    feed(0, 64, 3, 60, -1, n);
    check_bit(1'(n < 64), 1'b1, "buffer refused");
    check_vec(32'(q_data.size()), 32'h00000000, "no output while stalled");
    check_bit(seen[2], 1'b1, "halted");
    sink_stall = 1'b0;
    feed(n, 64, 3, 400, -1, n);
    expect_out(4, 4);
    $display("test stall done");
  endtask

  task automatic test_clear();
    // A partial period is left in flight so the clear has state to discard.
    feed(0, 6, 3, 200, -1, n);
    clear_req = 1'b1;
    @(negedge clock);
    clear_req = 1'b0;
    repeat (4) @(negedge clock);
    check_vec(32'(rate_now), 32'h00000008, "rate after clear");
    feed(0, 32, 3, 200, -1, n);
    expect_out(1, 8);
    $display("test clear done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clock);
    arst_n = 1'b1;
    run_en = 1'b1;
    repeat (4) @(negedge clock);
    test_stream();
    test_rate();
    test_last();
    test_stall();
    test_clear();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
